/* File: common/sgcr_map.svh */
// register offsets, field positions, reset values and timing counts of the global control bank
// Operation
// - pass-all-frames bit forwards bad frames too, only together with sniffer mode
// - transmit flow control enable cleared: never generate a PAUSE frame
// - receive flow control enable cleared: ignore received PAUSE frames
// - length check set: drop frame when Length/Type below 1500 mismatches length
// - address aging runs only while aging enable is set
// - fast age enable selects the fast aging period of about 800us
// - aggressive back-off bit selects non-standard back-off in half duplex
// - mismatch discard set blocks all VLAN crossing; cleared lets known unicast cross
// - port mirroring is supported only while mismatch discard is set
// - storm disable set regulates broadcast only; cleared adds DA[40] multicast
// - backpressure mode set is carrier-sense based, cleared is collision based
// - fair mode may drop non-flow-controlled traffic; cleared flow-controls the other port
// - no-excessive-collision-drop cleared drops after 16 collisions, set keeps retrying
// - huge packet set accepts up to 1916 bytes, overriding size check
// - size check cleared 1536 limit; set 1522 tagged, 1518 untagged; strap reset
// - priority reserve keeps 48 buffers per port for q3 to q1, only in multi-queue mode
// - link-change aging ages fast within 800us, then returns to about 200 seconds
`ifndef SGCR_MAP_SVH
`define SGCR_MAP_SVH
`define SGCR_OFF_CTRL_ONE      8'h03
`define SGCR_OFF_CTRL_TWO      8'h04
`define SGCR_ADDR_CTRL_ONE     8'h0c
`define SGCR_ADDR_CTRL_TWO     8'h10
`define SGCR_ADDR_STATUS       8'h14
`define SGCR_RST_CTRL_ONE      8'h30
`define SGCR_RST_CTRL_TWO      8'hf1
`define SGCR_RESERVED_MASK_ONE 8'hbf
`define SGCR_B1_PASS_ALL       7
`define SGCR_B1_TX_FC          5
`define SGCR_B1_RX_FC          4
`define SGCR_B1_LEN_CHECK      3
`define SGCR_B1_AGING          2
`define SGCR_B1_FAST_AGE       1
`define SGCR_B1_AGGR_BACKOFF   0
`define SGCR_B2_VLAN_DISCARD   7
`define SGCR_B2_STORM_MC_OFF   6
`define SGCR_B2_BP_CARRIER     5
`define SGCR_B2_FAIR           4
`define SGCR_B2_NO_COL_DROP    3
`define SGCR_B2_HUGE           2
`define SGCR_B2_SIZE_CHECK     1
`define SGCR_B2_PRIO_RESERVE   0
`define SGCR_LEN_TYPE_LIMIT    11'd1500
`define SGCR_SIZE_HUGE         11'd1916
`define SGCR_SIZE_LEGACY       11'd1536
`define SGCR_SIZE_TAGGED       11'd1522
`define SGCR_SIZE_UNTAGGED     11'd1518
`define SGCR_COLLISION_LIMIT   5'd16
`define SGCR_RESERVE_BUFFERS   6'd48
`define SGCR_CLK_MHZ           20
`define SGCR_FAST_AGE_US       800
`define SGCR_NORMAL_AGE_S      200
`endif

/* File: common/sgcr_pkg.sv */
// types shared by the global control bank
package sgcr_pkg;
  typedef enum logic [2:0] {
    SGCR_AGE_OFF    = 3'b001,
    SGCR_AGE_NORMAL = 3'b010,
    SGCR_AGE_FAST   = 3'b100
  } sgcr_age_type;
  typedef enum logic [1:0] {
    SGCR_W_IDLE = 2'b01,
    SGCR_W_RESP = 2'b10
  } sgcr_wr_type;
endpackage : sgcr_pkg

/* File: design/sgcr_regs.sv */
// global control registers one and two with AXI4-Lite access and decoded policy outputs
`timescale 1ns/10ps
`default_nettype none
`include "sgcr_map.svh"
module sgcr_regs
  import sgcr_pkg::*;
#(
  parameter int unsigned NORMAL_AGE_CYCLES = `SGCR_NORMAL_AGE_S * `SGCR_CLK_MHZ * 32'd1000000
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        switch_port_rx_strap_bit0,
  input  wire logic        sniffer_mode,
  input  wire logic        link_lost,
  input  wire logic        bad_frame,
  input  wire logic        len_mismatch,
  input  wire logic [10:0] len_type,
  input  wire logic        rx_pause,
  input  wire logic        tx_pause_req,
  input  wire logic        known_unicast,
  input  wire logic        da_broadcast,
  input  wire logic        da_bit40,
  input  wire logic [10:0] frame_size,
  input  wire logic        frame_tagged,
  input  wire logic [4:0]  collision_count,
  input  wire logic        multi_queue,
  output logic             forward_bad,
  output logic             gen_pause,
  output logic             honor_pause,
  output logic             drop_length,
  output logic             drop_size,
  output logic             age_tick,
  output logic             aggr_backoff,
  output logic             vlan_cross_ok,
  output logic             mirror_ok,
  output logic             storm_regulate,
  output logic             bp_carrier,
  output logic             fair_drop,
  output logic             excess_col_drop,
  output logic [5:0]       high_prio_reserve
);
  localparam int unsigned FAST_AGE_CYCLES = `SGCR_FAST_AGE_US * `SGCR_CLK_MHZ;

  if (NORMAL_AGE_CYCLES <= FAST_AGE_CYCLES) begin : g_age_check
    $error("normal aging must be longer than fast aging");
  end

  logic [7:0]   ctrl_one;
  logic [7:0]   ctrl_two;
  logic         aw_held;
  logic         w_held;
  logic [7:0]   aw_addr;
  logic [7:0]   w_data;
  logic         w_lane0;
  sgcr_wr_type  wr_state;
  sgcr_age_type age_state;
  logic         link_age;
  logic [31:0]  age_count;
  logic         strap_meta;
  logic         strap_sync;
  logic         strap_taken;

  // ************************************************************
  // strap capture
  // ************************************************************
  // the strap is a pin: synchronise, then catch it once after reset release
  always_ff @(posedge aclk) begin
    strap_meta <= switch_port_rx_strap_bit0;
    strap_sync <= strap_meta;
  end

  // ************************************************************
  // write channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= 8'h00;
      w_data   <= 8'h00;
      w_lane0  <= 1'b0;
      wr_state <= SGCR_W_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      case (wr_state)
        SGCR_W_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
          end
          if (aw_held && w_held) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[7:2] == `SGCR_ADDR_CTRL_ONE >> 2 || aw_addr[7:2] == `SGCR_ADDR_CTRL_TWO >> 2
                            || aw_addr[7:2] == `SGCR_ADDR_STATUS >> 2) ? 2'h0 : 2'h3;
            wr_state     <= SGCR_W_RESP;
          end
        end
        SGCR_W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state     <= SGCR_W_IDLE;
          end
        end
        default: wr_state <= SGCR_W_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= (wr_state == SGCR_W_IDLE) && !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= (wr_state == SGCR_W_IDLE) && !w_held && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_one    <= `SGCR_RST_CTRL_ONE;
      ctrl_two    <= `SGCR_RST_CTRL_TWO;
      strap_taken <= 1'b0;
    end else begin
      if (!strap_taken) begin
        strap_taken <= 1'b1;
        ctrl_two[`SGCR_B2_SIZE_CHECK] <= strap_sync;
      end
      if (wr_state == SGCR_W_IDLE && aw_held && w_held && w_lane0) begin
        if (aw_addr[7:2] == `SGCR_ADDR_CTRL_ONE >> 2) begin
          // reserved bit is kept at zero whatever software writes
          ctrl_one <= w_data & `SGCR_RESERVED_MASK_ONE;
        end
        if (aw_addr[7:2] == `SGCR_ADDR_CTRL_TWO >> 2) begin
          ctrl_two <= w_data;
        end
      end
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr[7:2])
          `SGCR_ADDR_CTRL_ONE >> 2: s_axi_rdata <= {24'h000000, ctrl_one};
          `SGCR_ADDR_CTRL_TWO >> 2: s_axi_rdata <= {24'h000000, ctrl_two};
          `SGCR_ADDR_STATUS >> 2:   s_axi_rdata <= {29'h00000000, age_state};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h3;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // aging timer
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_age <= 1'b0;
    end else if (link_lost) begin
      link_age <= 1'b1;
    end else if (age_tick) begin
      link_age <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      age_state <= SGCR_AGE_OFF;
      age_count <= 32'h00000000;
      age_tick  <= 1'b0;
    end else begin
      age_tick <= 1'b0;
      case (age_state)
        SGCR_AGE_OFF: age_count <= 32'h00000000;
        SGCR_AGE_NORMAL, SGCR_AGE_FAST: begin
          if ((age_state == SGCR_AGE_FAST && age_count >= FAST_AGE_CYCLES - 1)
              || age_count >= NORMAL_AGE_CYCLES - 1) begin
            age_count <= 32'h00000000;
            age_tick  <= 1'b1;
          end else begin
            age_count <= age_count + 32'h00000001;
          end
        end
        default: age_count <= 32'h00000000;
      endcase
      if (!ctrl_one[`SGCR_B1_AGING]) begin
        age_state <= SGCR_AGE_OFF;
      end else if (ctrl_one[`SGCR_B1_FAST_AGE] || link_age) begin
        age_state <= SGCR_AGE_FAST;
      end else begin
        age_state <= SGCR_AGE_NORMAL;
      end
    end
  end

  // ************************************************************
  // decoded policy
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      forward_bad       <= 1'b0;
      gen_pause         <= 1'b0;
      honor_pause       <= 1'b0;
      drop_length       <= 1'b0;
      drop_size         <= 1'b0;
      aggr_backoff      <= 1'b0;
      vlan_cross_ok     <= 1'b0;
      mirror_ok         <= 1'b0;
      storm_regulate    <= 1'b0;
      bp_carrier        <= 1'b0;
      fair_drop         <= 1'b0;
      excess_col_drop   <= 1'b0;
      high_prio_reserve <= 6'h00;
    end else begin
      forward_bad    <= bad_frame && ctrl_one[`SGCR_B1_PASS_ALL] && sniffer_mode;
      gen_pause      <= tx_pause_req && ctrl_one[`SGCR_B1_TX_FC];
      honor_pause    <= rx_pause && ctrl_one[`SGCR_B1_RX_FC];
      drop_length    <= ctrl_one[`SGCR_B1_LEN_CHECK] && len_type < `SGCR_LEN_TYPE_LIMIT && len_mismatch;
      if (ctrl_two[`SGCR_B2_HUGE]) begin
        drop_size <= frame_size > `SGCR_SIZE_HUGE;
      end else if (ctrl_two[`SGCR_B2_SIZE_CHECK]) begin
        drop_size <= frame_size > (frame_tagged ? `SGCR_SIZE_TAGGED : `SGCR_SIZE_UNTAGGED);
      end else begin
        drop_size <= frame_size > `SGCR_SIZE_LEGACY;
      end
      aggr_backoff   <= ctrl_one[`SGCR_B1_AGGR_BACKOFF];
      vlan_cross_ok  <= !ctrl_two[`SGCR_B2_VLAN_DISCARD] && known_unicast;
      mirror_ok      <= ctrl_two[`SGCR_B2_VLAN_DISCARD];
      storm_regulate <= da_broadcast || (!ctrl_two[`SGCR_B2_STORM_MC_OFF] && da_bit40);
      bp_carrier     <= ctrl_two[`SGCR_B2_BP_CARRIER];
      fair_drop      <= ctrl_two[`SGCR_B2_FAIR];
      excess_col_drop <= !ctrl_two[`SGCR_B2_NO_COL_DROP] && collision_count >= `SGCR_COLLISION_LIMIT;
      high_prio_reserve <= (ctrl_two[`SGCR_B2_PRIO_RESERVE] && multi_queue) ? `SGCR_RESERVE_BUFFERS : 6'h00;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_pass_all_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    forward_bad |-> $past(ctrl_one[7] && sniffer_mode)) else $error("bad frame forwarded without enable");
  a_tx_pause_off: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!ctrl_one[5]) |-> !gen_pause) else $error("pause generated while disabled");
  a_rx_pause_off: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!ctrl_one[4]) |-> !honor_pause) else $error("pause honoured while disabled");
  a_len_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    drop_length |-> $past(len_type) < 11'd1500) else $error("length drop above limit");
  a_aging_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_one[2] [*3] |-> age_state == SGCR_AGE_OFF && !age_tick) else $error("aging while disabled");
  a_huge_size: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ctrl_two[2]) && $past(frame_size) == 11'd1916 |-> !drop_size) else $error("1916 byte frame dropped");
  a_size_tagged: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ctrl_two[2:1] == 2'b01 && frame_tagged && frame_size == 11'd1523) |-> drop_size)
    else $error("oversize tagged frame kept");
  a_vlan_block: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ctrl_two[7]) |-> !vlan_cross_ok) else $error("vlan crossing while discard set");
  a_collision_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!ctrl_two[3] && collision_count == 5'd16) |-> excess_col_drop) else $error("16 collisions not dropped");
  a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_one[6]) else $error("reserved bit set");
endmodule : sgcr_regs
`default_nettype wire

/* File: sim/sgcr_regs_tb.sv */
// self-checking testbench for the global control register bank
`timescale 1ns/10ps
`default_nettype none
`include "sgcr_map.svh"
module sgcr_regs_tb
  import sgcr_pkg::*;
;
  // ***************
  // signals
  // ***************
  localparam int NORMAL = 17000;
  localparam int FAST   = `SGCR_FAST_AGE_US * `SGCR_CLK_MHZ;
  logic        aclk = 1'b0, aresetn = 1'b0, switch_port_rx_strap_bit0 = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        sniffer_mode = 1'b0, link_lost = 1'b0, bad_frame = 1'b0, len_mismatch = 1'b0, rx_pause = 1'b0;
  logic        tx_pause_req = 1'b0, known_unicast = 1'b0, da_broadcast = 1'b0, da_bit40 = 1'b0;
  logic        frame_tagged = 1'b0, multi_queue = 1'b0;
  logic [10:0] len_type = 11'h000, frame_size = 11'h000;
  logic [4:0]  collision_count = 5'h00;
  logic        forward_bad, gen_pause, honor_pause, drop_length, drop_size, age_tick, aggr_backoff;
  logic        vlan_cross_ok, mirror_ok, storm_regulate, bp_carrier, fair_drop, excess_col_drop;
  logic [5:0]  high_prio_reserve;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  // the normal aging period is shortened so the run stays short; it must stay above the fast period
  sgcr_regs #(.NORMAL_AGE_CYCLES(NORMAL)) u_sgcr_regs (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .switch_port_rx_strap_bit0, .sniffer_mode, .link_lost, .bad_frame, .len_mismatch, .len_type,
    .rx_pause, .tx_pause_req, .known_unicast, .da_broadcast, .da_bit40, .frame_size, .frame_tagged,
    .collision_count, .multi_queue, .forward_bad, .gen_pause, .honor_pause, .drop_length, .drop_size,
    .age_tick, .aggr_backoff, .vlan_cross_ok, .mirror_ok, .storm_regulate, .bp_carrier, .fair_drop,
    .excess_col_drop, .high_prio_reserve);

  initial begin
    forever #25 aclk = ~aclk;
  end

  // ***************
  // helpers
  // ***************
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask : check

  task automatic chk(input string what, input logic seen, input logic exp);
    check(what, {31'h0, seen}, {31'h0, exp});
  endtask : chk

  task automatic hang(input string what);
    $display("ERROR %s expected answer seen timeout", what);
    n_mismatch++;
    summarize();
  endtask : hang

  // ready is read mid-cycle: it stays put up to the next rising edge, where the transfer is taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw_done = 1'b0;
    logic w_done  = 1'b0;
    logic aw_hit;
    logic w_hit;
    int   n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge aclk);
      aw_hit = !aw_done && (s_axi_awready === 1'b1);
      w_hit  = !w_done && (s_axi_wready === 1'b1);
      @(posedge aclk);
      if (aw_hit) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_hit) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
      n++;
      if (n > 50) hang("write request");
    end
    do begin
      @(negedge aclk);
      n++;
      if (n > 100) hang("write response");
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hit;
    int   n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge aclk);
      hit = s_axi_arready;
      @(posedge aclk);
      n++;
      if (n > 50) hang("read request");
    end while (hit !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      n++;
      if (n > 100) hang("read response");
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'h1, r);
    check("write response", {30'h0, r}, 32'h0);
  endtask : reg_wr

  task automatic reg_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(what, d, exp);
  endtask : reg_rd

  // policy outputs are registered, so they are looked at one edge after the inputs change
  task automatic settle;
    @(posedge aclk);
    @(negedge aclk);
  endtask : settle

  task automatic wait_tick(input int limit, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      if (n > limit) hang("age tick");
    end while (age_tick !== 1'b1);
  endtask : wait_tick

  // ***************
  // scenarios
  // ***************
  task automatic t_access;
    logic [31:0] d;
    logic [1:0]  r;
    reg_rd("ctrl one reset", `SGCR_ADDR_CTRL_ONE, 32'h30);
    reg_rd("ctrl two reset", `SGCR_ADDR_CTRL_TWO, 32'hf3);
    // software keeps the reserved bit clear; the upper lanes carry junk to show they are ignored
    reg_wr(`SGCR_ADDR_CTRL_ONE, 32'hffff_ffbf);
    reg_rd("reserved bit", `SGCR_ADDR_CTRL_ONE, 32'hbf);
    axi_write(`SGCR_ADDR_CTRL_ONE, 32'h0, 4'h0, r);
    reg_rd("masked write", `SGCR_ADDR_CTRL_ONE, 32'hbf);
    axi_write(8'h18, 32'h0, 4'h1, r);
    check("unmapped bresp", {30'h0, r}, 32'h3);
    axi_read(8'h18, d, r);
    check("unmapped rresp", {30'h0, r}, 32'h3);
    check("unmapped rdata", d, 32'h0);
    reg_wr(`SGCR_ADDR_CTRL_ONE, 32'h30);
  endtask : t_access

  task automatic t_frames;
    @(posedge aclk);
    {tx_pause_req, rx_pause, bad_frame, sniffer_mode, len_mismatch} <= 5'h1f;
    len_type <= 11'd1499;
    settle();
    chk("gen pause", gen_pause, 1'b1);
    chk("honor pause", honor_pause, 1'b1);
    chk("forward bad", forward_bad, 1'b0);
    chk("drop length", drop_length, 1'b0);
    chk("aggr backoff off", aggr_backoff, 1'b0);
    reg_wr(`SGCR_ADDR_CTRL_ONE, 32'h89);
    settle();
    chk("gen pause off", gen_pause, 1'b0);
    chk("honor pause off", honor_pause, 1'b0);
    chk("forward bad on", forward_bad, 1'b1);
    chk("drop length on", drop_length, 1'b1);
    chk("aggr backoff", aggr_backoff, 1'b1);
    @(posedge aclk);
    len_type     <= `SGCR_LEN_TYPE_LIMIT;
    sniffer_mode <= 1'b0;
    settle();
    chk("length at limit", drop_length, 1'b0);
    chk("no sniffer", forward_bad, 1'b0);
    reg_wr(`SGCR_ADDR_CTRL_ONE, 32'h30);
  endtask : t_frames

  task automatic size_case(input logic [31:0] c2, input logic [10:0] sz, input logic tag, input logic exp);
    reg_wr(`SGCR_ADDR_CTRL_TWO, c2);
    @(posedge aclk);
    frame_size   <= sz;
    frame_tagged <= tag;
    settle();
    chk("drop size", drop_size, exp);
  endtask : size_case

  task automatic t_policy;
    size_case(32'hf7, 11'd1916, 1'b0, 1'b0);
    size_case(32'hf7, 11'd1917, 1'b1, 1'b1);
    size_case(32'hf1, 11'd1536, 1'b0, 1'b0);
    size_case(32'hf1, 11'd1537, 1'b0, 1'b1);
    size_case(32'hf3, 11'd1522, 1'b1, 1'b0);
    size_case(32'hf3, 11'd1523, 1'b1, 1'b1);
    size_case(32'hf3, 11'd1519, 1'b0, 1'b1);
    @(posedge aclk);
    {known_unicast, da_bit40, multi_queue} <= 3'h7;
    collision_count <= `SGCR_COLLISION_LIMIT;
    settle();
    chk("vlan cross", vlan_cross_ok, 1'b0);
    chk("mirror", mirror_ok, 1'b1);
    chk("storm mc", storm_regulate, 1'b0);
    chk("bp carrier", bp_carrier, 1'b1);
    chk("fair", fair_drop, 1'b1);
    chk("col drop", excess_col_drop, 1'b1);
    check("reserve", {26'h0, high_prio_reserve}, 32'd48);
    reg_wr(`SGCR_ADDR_CTRL_TWO, 32'h0a);
    reg_rd("ctrl two kept", `SGCR_ADDR_CTRL_TWO, 32'h0a);
    @(negedge aclk);
    chk("vlan cross on", vlan_cross_ok, 1'b1);
    chk("mirror off", mirror_ok, 1'b0);
    chk("storm mc on", storm_regulate, 1'b1);
    chk("bp collision", bp_carrier, 1'b0);
    chk("fair off", fair_drop, 1'b0);
    chk("col retry", excess_col_drop, 1'b0);
    check("reserve off", {26'h0, high_prio_reserve}, 32'd0);
    reg_wr(`SGCR_ADDR_CTRL_TWO, 32'hf1);
    @(posedge aclk);
    {known_unicast, da_bit40, multi_queue, da_broadcast} <= 4'h1;
    collision_count <= 5'd15;
    settle();
    chk("unknown cross", vlan_cross_ok, 1'b0);
    chk("storm bc", storm_regulate, 1'b1);
    chk("col below", excess_col_drop, 1'b0);
    check("reserve single", {26'h0, high_prio_reserve}, 32'd0);
  endtask : t_policy

  task automatic t_aging;
    int n;
    int ticks = 0;
    reg_rd("age off", `SGCR_ADDR_STATUS, {29'h0, SGCR_AGE_OFF});
    repeat (1000) begin
      @(negedge aclk);
      ticks += int'(age_tick === 1'b1);
    end
    check("ticks off", ticks, 32'd0);
    reg_wr(`SGCR_ADDR_CTRL_ONE, 32'h36);
    reg_rd("age fast", `SGCR_ADDR_STATUS, {29'h0, SGCR_AGE_FAST});
    wait_tick(FAST + NORMAL, n);
    wait_tick(FAST + 10, n);
    chk("fast period", n >= FAST - 2 && n <= FAST + 2, 1'b1);
    reg_wr(`SGCR_ADDR_CTRL_ONE, 32'h34);
    reg_rd("age normal", `SGCR_ADDR_STATUS, {29'h0, SGCR_AGE_NORMAL});
    @(posedge aclk);
    link_lost <= 1'b1;
    @(posedge aclk);
    link_lost <= 1'b0;
    reg_rd("link fast", `SGCR_ADDR_STATUS, {29'h0, SGCR_AGE_FAST});
    wait_tick(FAST + 10, n);
    // the tick clears the link flag one edge later and the age state follows one edge after that
    repeat (2) @(posedge aclk);
    reg_rd("link back", `SGCR_ADDR_STATUS, {29'h0, SGCR_AGE_NORMAL});
    wait_tick(NORMAL + 10, n);
    chk("normal period", n >= NORMAL - 10 && n <= NORMAL + 2, 1'b1);
  endtask : t_aging

  // ***************
  // main
  // ***************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_access();
    t_frames();
    t_policy();
    t_aging();
    summarize();
  end
endmodule : sgcr_regs_tb
`default_nettype wire
